// ---- bench/irq_conv_sink.sv ----
`timescale 1ns/1ns
// Stands in for the interrupt controller and the converter trigger input.
// It counts every cycle that a pulse is high, so a pulse that is too long
// shows up as an extra count.
module irq_conv_sink (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Pulses from the prescaler.
	input wire logic i_irq_pulse,
	input wire logic i_conv_pulse,
	// Pulse totals.
	output int o_irq_cnt,
	output int o_conv_cnt
);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_cnt <= 0;
			o_conv_cnt <= 0;
		end else begin
			o_irq_cnt <= o_irq_cnt + int'(i_irq_pulse === 1'b1);
			o_conv_cnt <= o_conv_cnt + int'(i_conv_pulse === 1'b1);
		end
	end
endmodule // irq_conv_sink

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	localparam logic [7:0] A_PS = pwm_event_prescaler_pkg::OFS_PRESCALE;
	localparam logic [7:0] A_SEL = pwm_event_prescaler_pkg::OFS_SELECT;
	localparam logic [7:0] A_FLG = pwm_event_prescaler_pkg::OFS_FLAG;
	localparam logic [7:0] A_CLR = pwm_event_prescaler_pkg::OFS_CLEAR;
	localparam logic [7:0] A_FRC = pwm_event_prescaler_pkg::OFS_FORCE;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq_ev = 1'b0;
	logic conv_ev = 1'b0;
	logic irq_out;
	logic conv_out;
	int irq_cnt;
	int conv_cnt;
	int mismatches = 0;
	int compares = 0;
	int ei = 0;
	int ec = 0;
	logic [31:0] q;
	logic err;

	always #10 i_clk = ~i_clk;

	pwm_event_prescaler u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_irq_event(irq_ev),
		.i_conv_a_event(conv_ev), .o_irq_pulse_out(irq_out),
		.o_conv_a_start_pulse(conv_out));

	irq_conv_sink u_sink (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_irq_pulse(irq_out), .i_conv_pulse(conv_out),
		.o_irq_cnt(irq_cnt), .o_conv_cnt(conv_cnt));

	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Events come on consecutive cycles, then the pulses get time to land.
	task automatic ev(input logic ir, input logic cv, input int n);
		repeat (n) begin
			@(posedge i_clk);
			irq_ev <= ir;
			conv_ev <= cv;
		end
		@(posedge i_clk);
		irq_ev <= 1'b0;
		conv_ev <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask

	task automatic irq_chk(input logic [1:0] cnt, input logic flg);
		apb(1'b0, A_PS, 32'h0000_0000);
		chk("irq count", {30'h0, q[3:2]}, {30'h0, cnt});
		apb(1'b0, A_FLG, 32'h0000_0000);
		chk("irq flag", {31'h0, q[0]}, {31'h0, flg});
		chk("irq pulses", 32'(irq_cnt), 32'(ei));
	endtask

	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'b1;
		foreach (q[i]) begin
			if (i < 3) begin
				apb(1'b0, 8'(4 * i), 32'h0000_0000);
				chk("reset value", q, 32'h0000_0000);
			end
		end
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped err", {31'h0, err}, 32'h0000_0001);
		chk("unmapped data", q, 32'h0000_0000);
		wr(A_PS, 32'hFFFF_FFFF);
		apb(1'b0, A_PS, 32'h0000_0000);
		chk("prescale rw", q, 32'h0000_0303);
		wr(A_SEL, 32'h0000_0001);
		for (int p = 1; p < 4; p++) begin
			wr(A_PS, 32'(p));
			ev(1'b1, 1'b0, p - 1);
			irq_chk(2'(p - 1), 1'b0);
			ev(1'b1, 1'b0, 1);
			ei++;
			irq_chk(2'h0, 1'b1);
			ev(1'b1, 1'b0, 3);
			irq_chk(2'(p), 1'b1);
			wr(A_PS, 32'h0000_0000);
			irq_chk(2'h0, 1'b1);
			wr(A_CLR, 32'h0000_0001);
			irq_chk(2'h0, 1'b0);
		end
		wr(A_FRC, 32'h0000_0001);
		ev(1'b0, 1'b0, 0);
		irq_chk(2'h0, 1'b0);
		wr(A_PS, 32'h0000_0002);
		wr(A_FRC, 32'h0000_0001);
		ev(1'b0, 1'b0, 0);
		ei++;
		irq_chk(2'h0, 1'b1);
		wr(A_CLR, 32'h0000_0001);
		wr(A_PS, 32'h0000_0003);
		ev(1'b1, 1'b0, 2);
		wr(A_PS, 32'h0000_0002);
		ev(1'b0, 1'b0, 0);
		ei++;
		irq_chk(2'h0, 1'b1);
		ev(1'b1, 1'b0, 2);
		irq_chk(2'h2, 1'b1);
		wr(A_CLR, 32'h0000_0001);
		ev(1'b0, 1'b0, 0);
		ei++;
		irq_chk(2'h0, 1'b1);
		wr(A_CLR, 32'h0000_0001);
		wr(A_SEL, 32'h0000_0000);
		wr(A_PS, 32'h0000_0001);
		ev(1'b1, 1'b0, 2);
		irq_chk(2'h1, 1'b0);
		wr(A_PS, 32'h0000_0003);
		// The event lands in the access cycle of the period write.
		fork
			apb(1'b1, A_PS, 32'h0000_0002);
			begin
				repeat (2) @(posedge i_clk);
				irq_ev <= 1'b1;
				@(posedge i_clk);
				irq_ev <= 1'b0;
			end
		join
		ev(1'b0, 1'b0, 0);
		irq_chk(2'h2, 1'b0);
		wr(A_SEL, 32'h0000_0002);
		for (int p = 1; p < 4; p++) begin
			wr(A_PS, 32'(p) << 8);
			ev(1'b0, 1'b1, 3 * p);
			ec += 3;
			chk("conv pulses", 32'(conv_cnt), 32'(ec));
			apb(1'b0, A_PS, 32'h0000_0000);
			chk("conv count", {30'h0, q[11:10]}, 32'h0000_0000);
			apb(1'b0, A_FLG, 32'h0000_0000);
			chk("conv flag", {31'h0, q[2]}, 32'h0000_0001);
		end
		wr(A_SEL, 32'h0000_0000);
		ev(1'b0, 1'b1, 3);
		chk("conv disabled", 32'(conv_cnt), 32'(ec));
		wr(A_SEL, 32'h0000_0002);
		// Re-enabling releases the pulse parked at the period.
		ec++;
		wr(A_PS, 32'h0000_0000);
		ev(1'b0, 1'b1, 3);
		chk("conv period off", 32'(conv_cnt), 32'(ec));
		final_report();
	end

	// The sequence needs about four hundred cycles.
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		final_report();
	end
endmodule // tb_top

// ---- hdl/prescale_counter.sv ----
`timescale 1ns/1ns
module prescale_counter (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Control and status toward the register side.
	prescale_if.cnt ifc
);
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] count_reg;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] count_next;
	logic fire_reg;
	logic fire_next;
	logic at_stop;
	logic inc;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] sum;

	always_comb begin
		// A stalled counter parks on the period so the pending event is kept.
		at_stop = (!ifc.enable || ifc.blocked) && (count_reg == ifc.period);
		inc = ifc.evt && !at_stop;
		sum = count_reg + {{(pwm_event_prescaler_pkg::CNT_W-1){1'b0}}, inc};
		// A count parked on the period fires as soon as the stall lifts,
		// even if a fresh event lands in that cycle; otherwise the pending
		// pulse would be lost and the count would run past the period.
		// The same compare fires a period written equal to the count.
		fire_next = (ifc.period != pwm_event_prescaler_pkg::PRD_OFF)
			&& ifc.enable && !ifc.blocked
			&& ((sum == ifc.period) || (count_reg == ifc.period)
			|| ifc.force_req);
		if (ifc.period == pwm_event_prescaler_pkg::PRD_OFF) begin
			count_next = pwm_event_prescaler_pkg::CNT_RST;
		end else if (fire_next) begin
			count_next = pwm_event_prescaler_pkg::CNT_RST;
		end else begin
			count_next = sum;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_reg <= pwm_event_prescaler_pkg::CNT_RST;
			fire_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			fire_reg <= fire_next;
		end
	end

	assign ifc.count = count_reg;
	assign ifc.fire = fire_reg;

	a_fire_clears_count: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		fire_reg |-> count_reg == pwm_event_prescaler_pkg::CNT_RST)
		else $error("count not cleared with pulse");
	a_off_no_fire: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(ifc.period) == pwm_event_prescaler_pkg::PRD_OFF |-> !fire_reg)
		else $error("pulse with period code off");
endmodule // prescale_counter

// ---- hdl/prescale_if.sv ----
`timescale 1ns/1ns
interface prescale_if;
	logic evt;
	logic force_req;
	logic enable;
	logic blocked;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] period;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] count;
	logic fire;

	modport ctl (
		output evt, force_req, enable, blocked, period,
		input count, fire
	);
	modport cnt (
		input evt, force_req, enable, blocked, period,
		output count, fire
	);
endinterface

// ---- hdl/pwm_event_prescaler.sv ----
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module pwm_event_prescaler (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [pwm_event_prescaler_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [pwm_event_prescaler_pkg::DATA_W-1:0] i_pwdata,
	output logic [pwm_event_prescaler_pkg::DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Selected time-base events, one pulse per event.
	input wire logic i_irq_event,
	input wire logic i_conv_a_event,
	// Pulses toward the interrupt controller and the converter.
	output logic o_irq_pulse_out,
	output logic o_conv_a_start_pulse
);
	prescale_if irq_ifc ();
	prescale_if conv_ifc ();

	logic [pwm_event_prescaler_pkg::CNT_W-1:0] irq_period_reg;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] irq_period_next;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] conv_period_reg;
	logic [pwm_event_prescaler_pkg::CNT_W-1:0] conv_period_next;
	logic irq_enable_reg;
	logic irq_enable_next;
	logic conv_enable_reg;
	logic conv_enable_next;
	logic irq_flag_reg;
	logic irq_flag_next;
	logic conv_flag_reg;
	logic conv_flag_next;
	logic irq_force_reg;
	logic irq_force_next;
	logic conv_force_reg;
	logic conv_force_next;
	logic [pwm_event_prescaler_pkg::DATA_W-1:0] prdata_reg;
	logic [pwm_event_prescaler_pkg::DATA_W-1:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic setup;
	logic wr;
	logic mapped;
	logic [pwm_event_prescaler_pkg::DATA_W-1:0] prescale_view;

	function automatic logic hit(
		input logic [pwm_event_prescaler_pkg::ADDR_W-1:0] addr,
		input logic [pwm_event_prescaler_pkg::ADDR_W-1:0] ofs
	);
		hit = (addr == ofs);
	endfunction

	// Counter hookup; the interrupt path also blocks in its own pulse
	// cycle, before the flag has had a chance to latch.
	always_comb begin
		irq_ifc.evt = i_irq_event;
		irq_ifc.force_req = irq_force_reg;
		irq_ifc.enable = irq_enable_reg;
		irq_ifc.blocked = irq_flag_reg || irq_ifc.fire;
		irq_ifc.period = irq_period_reg;
		conv_ifc.evt = i_conv_a_event;
		conv_ifc.force_req = conv_force_reg;
		conv_ifc.enable = conv_enable_reg;
		conv_ifc.blocked = 1'b0;
		conv_ifc.period = conv_period_reg;
	end

	prescale_counter u_irq_counter (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.ifc(irq_ifc.cnt)
	);

	prescale_counter u_conv_counter (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.ifc(conv_ifc.cnt)
	);

	// Register read views.
	always_comb begin
		prescale_view = pwm_event_prescaler_pkg::DATA_RST;
		prescale_view[pwm_event_prescaler_pkg::IRQ_PRD_LSB +:
			pwm_event_prescaler_pkg::CNT_W] = irq_period_reg;
		prescale_view[pwm_event_prescaler_pkg::IRQ_CNT_LSB +:
			pwm_event_prescaler_pkg::CNT_W] = irq_ifc.count;
		prescale_view[pwm_event_prescaler_pkg::RSVD_LSB +:
			pwm_event_prescaler_pkg::RSVD_W] =
			pwm_event_prescaler_pkg::RSVD_VAL;
		prescale_view[pwm_event_prescaler_pkg::CONV_PRD_LSB +:
			pwm_event_prescaler_pkg::CNT_W] = conv_period_reg;
		prescale_view[pwm_event_prescaler_pkg::CONV_CNT_LSB +:
			pwm_event_prescaler_pkg::CNT_W] = conv_ifc.count;
	end

	// APB: data are captured in the setup cycle so that every access
	// completes with no wait state; counts are those seen at setup.
	always_comb begin
		setup = i_psel && !i_penable;
		wr = i_psel && i_penable && pready_reg && i_pwrite;
		mapped = hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE)
			|| hit(i_paddr, pwm_event_prescaler_pkg::OFS_SELECT)
			|| hit(i_paddr, pwm_event_prescaler_pkg::OFS_FLAG)
			|| hit(i_paddr, pwm_event_prescaler_pkg::OFS_CLEAR)
			|| hit(i_paddr, pwm_event_prescaler_pkg::OFS_FORCE);
		pready_next = setup;
		pslverr_next = setup && !mapped;
		prdata_next = pwm_event_prescaler_pkg::DATA_RST;
		if (setup && !i_pwrite) begin
			if (hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE)) begin
				prdata_next = prescale_view;
			end else if (hit(i_paddr, pwm_event_prescaler_pkg::OFS_SELECT)) begin
				prdata_next[pwm_event_prescaler_pkg::SEL_IRQ_EN_BIT] =
					irq_enable_reg;
				prdata_next[pwm_event_prescaler_pkg::SEL_CONV_EN_BIT] =
					conv_enable_reg;
			end else if (hit(i_paddr, pwm_event_prescaler_pkg::OFS_FLAG)) begin
				prdata_next[pwm_event_prescaler_pkg::EVT_IRQ_BIT] = irq_flag_reg;
				prdata_next[pwm_event_prescaler_pkg::EVT_CONV_BIT] =
					conv_flag_reg;
			end
		end
	end

	// Control registers, flags and force strobes.
	always_comb begin
		irq_period_next = irq_period_reg;
		conv_period_next = conv_period_reg;
		irq_enable_next = irq_enable_reg;
		conv_enable_next = conv_enable_reg;
		irq_force_next = 1'b0;
		conv_force_next = 1'b0;
		irq_flag_next = irq_flag_reg;
		conv_flag_next = conv_flag_reg;
		if (wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE)) begin
			irq_period_next = i_pwdata[pwm_event_prescaler_pkg::IRQ_PRD_LSB +:
				pwm_event_prescaler_pkg::CNT_W];
			conv_period_next = i_pwdata[pwm_event_prescaler_pkg::CONV_PRD_LSB +:
				pwm_event_prescaler_pkg::CNT_W];
		end
		if (wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_SELECT)) begin
			irq_enable_next = i_pwdata[pwm_event_prescaler_pkg::SEL_IRQ_EN_BIT];
			conv_enable_next = i_pwdata[pwm_event_prescaler_pkg::SEL_CONV_EN_BIT];
		end
		if (wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_FORCE)) begin
			irq_force_next = i_pwdata[pwm_event_prescaler_pkg::EVT_IRQ_BIT];
			conv_force_next = i_pwdata[pwm_event_prescaler_pkg::EVT_CONV_BIT];
		end
		if (wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_CLEAR)) begin
			if (i_pwdata[pwm_event_prescaler_pkg::EVT_IRQ_BIT]) begin
				irq_flag_next = 1'b0;
			end
			if (i_pwdata[pwm_event_prescaler_pkg::EVT_CONV_BIT]) begin
				conv_flag_next = 1'b0;
			end
		end
		// A pulse in the clearing cycle wins, so no event is lost.
		if (irq_ifc.fire) begin
			irq_flag_next = 1'b1;
		end
		if (conv_ifc.fire) begin
			conv_flag_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_period_reg <= pwm_event_prescaler_pkg::PRD_OFF;
			conv_period_reg <= pwm_event_prescaler_pkg::PRD_OFF;
			irq_enable_reg <= 1'b0;
			conv_enable_reg <= 1'b0;
			irq_flag_reg <= 1'b0;
			conv_flag_reg <= 1'b0;
			irq_force_reg <= 1'b0;
			conv_force_reg <= 1'b0;
			prdata_reg <= pwm_event_prescaler_pkg::DATA_RST;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			irq_period_reg <= irq_period_next;
			conv_period_reg <= conv_period_next;
			irq_enable_reg <= irq_enable_next;
			conv_enable_reg <= conv_enable_next;
			irq_flag_reg <= irq_flag_next;
			conv_flag_reg <= conv_flag_next;
			irq_force_reg <= irq_force_next;
			conv_force_reg <= conv_force_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_irq_pulse_out = irq_ifc.fire;
	assign o_conv_a_start_pulse = conv_ifc.fire;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_irq_needs_enable: assert property (
		o_irq_pulse_out |-> $past(irq_enable_reg))
		else $error("interrupt pulse while disabled");
	a_conv_needs_enable: assert property (
		o_conv_a_start_pulse |-> $past(conv_enable_reg))
		else $error("conversion pulse while disabled");
	a_irq_flag_blocks: assert property (
		$past(irq_flag_reg) |-> !o_irq_pulse_out)
		else $error("interrupt pulse while flag set");
	a_irq_sets_flag: assert property (
		o_irq_pulse_out |=> irq_flag_reg ##1 !o_irq_pulse_out)
		else $error("interrupt flag not latched");
	a_conv_sets_flag: assert property (
		o_conv_a_start_pulse |=> conv_flag_reg)
		else $error("conversion flag not latched");
	a_conv_count_clears: assert property (
		o_conv_a_start_pulse |-> conv_ifc.count == pwm_event_prescaler_pkg::CNT_RST)
		else $error("conversion count not cleared");
	a_irq_count_hold: assert property (
		(!irq_enable_reg && irq_period_reg != pwm_event_prescaler_pkg::PRD_OFF
		&& irq_ifc.count == irq_period_reg && !wr)
		|=> irq_ifc.count == $past(irq_ifc.count))
		else $error("stalled interrupt count moved");
	a_irq_counts_event: assert property (
		(i_irq_event && irq_enable_reg && !irq_ifc.blocked && !irq_force_reg
		&& irq_ifc.count == 2'h0 && irq_period_reg == 2'h3)
		|=> irq_ifc.count == 2'h1)
		else $error("interrupt event not counted");
	a_reserved_zero: assert property (
		(setup && !i_pwrite && hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE))
		|=> o_pready && o_prdata[7:4] == 4'h0)
		else $error("reserved bits not zero");
	// The parked and write-coincident checks aim at corners where a lost
	// event would otherwise only show up as a missing interrupt much later.
	a_irq_one_cycle: assert property (
		o_irq_pulse_out |=> !o_irq_pulse_out)
		else $error("interrupt pulse longer than one cycle");
	a_irq_count_clears: assert property (
		o_irq_pulse_out
		|-> irq_ifc.count == pwm_event_prescaler_pkg::CNT_RST)
		else $error("interrupt count not cleared");
	a_irq_off_quiet: assert property (
		irq_period_reg == pwm_event_prescaler_pkg::PRD_OFF
		|=> !o_irq_pulse_out
		&& irq_ifc.count == pwm_event_prescaler_pkg::CNT_RST)
		else $error("interrupt path active with period off");
	a_conv_off_quiet: assert property (
		conv_period_reg == pwm_event_prescaler_pkg::PRD_OFF
		|=> !o_conv_a_start_pulse)
		else $error("conversion pulse with period off");
	a_irq_flag_clears: assert property (
		(wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_CLEAR)
		&& i_pwdata[pwm_event_prescaler_pkg::EVT_IRQ_BIT] && !irq_ifc.fire)
		|=> !irq_flag_reg)
		else $error("interrupt flag not cleared");
	a_irq_write_counts: assert property (
		(i_irq_event && wr
		&& hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE)
		&& !irq_force_reg
		&& irq_period_reg != pwm_event_prescaler_pkg::PRD_OFF
		&& irq_ifc.count != irq_period_reg
		&& irq_ifc.count + 2'h1 != irq_period_reg)
		|=> irq_ifc.count == $past(irq_ifc.count) + 2'h1)
		else $error("event lost during period write");
	a_conv_counts_event: assert property (
		(i_conv_a_event && !conv_force_reg
		&& conv_period_reg != pwm_event_prescaler_pkg::PRD_OFF
		&& conv_ifc.count != conv_period_reg
		&& conv_ifc.count + 2'h1 != conv_period_reg)
		|=> conv_ifc.count == $past(conv_ifc.count) + 2'h1)
		else $error("conversion event not counted");
	a_irq_parked_fires: assert property (
		(wr && hit(i_paddr, pwm_event_prescaler_pkg::OFS_CLEAR)
		&& i_pwdata[pwm_event_prescaler_pkg::EVT_IRQ_BIT]
		&& irq_flag_reg && irq_enable_reg
		&& irq_period_reg != pwm_event_prescaler_pkg::PRD_OFF
		&& irq_ifc.count == irq_period_reg)
		|=> ##1 o_irq_pulse_out)
		else $error("parked interrupt lost after clear");

	c_irq_pulse: cover property (o_irq_pulse_out);
	c_conv_with_flag: cover property (conv_flag_reg && o_conv_a_start_pulse);
	c_irq_parked: cover property (irq_flag_reg && i_irq_event
		&& irq_ifc.count == irq_period_reg);
	c_force_irq: cover property (irq_force_reg ##1 o_irq_pulse_out);
	c_event_on_write: cover property (i_irq_event && wr
		&& hit(i_paddr, pwm_event_prescaler_pkg::OFS_PRESCALE));
endmodule // pwm_event_prescaler

// ---- hdl/pwm_event_prescaler_pkg.sv ----
package pwm_event_prescaler_pkg;

	// Bus geometry.
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 2;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h10;

	// Prescale register fields.
	localparam int IRQ_PRD_LSB = 0;
	localparam int IRQ_CNT_LSB = 2;
	localparam int RSVD_LSB = 4;
	localparam int RSVD_W = 4;
	localparam int CONV_PRD_LSB = 8;
	localparam int CONV_CNT_LSB = 10;

	// Select, flag, clear and force register bits.
	localparam int SEL_IRQ_EN_BIT = 0;
	localparam int SEL_CONV_EN_BIT = 1;
	localparam int EVT_IRQ_BIT = 0;
	localparam int EVT_CONV_BIT = 2;

	// Period code that switches a counter off, and reset values.
	localparam logic [CNT_W-1:0] PRD_OFF = 2'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [RSVD_W-1:0] RSVD_VAL = 4'h0;

endpackage
